/* File: pkg/mbrp_consts.svh */
// Purpose: timing counts and field positions for the meter readout port
// Assumes: 10 MHz clock
// Notes: definitions only
`ifndef MBRP_CONSTS_SVH
`define MBRP_CONSTS_SVH
`define MBRP_CLK_HZ 10000000
`define MBRP_VALID_MS 150
`define MBRP_RATE_PER_S 3
`define MBRP_VALID_CYC ((`MBRP_CLK_HZ / 1000) * `MBRP_VALID_MS)
`define MBRP_PERIOD_CYC (`MBRP_CLK_HZ / `MBRP_RATE_PER_S)
`define MBRP_STEP_CYC 1000
`define MBRP_FULL_COUNT 40000
`define MBRP_DIGITS 5
`define MBRP_BCD_W 4
`define MBRP_WORD_W 22
`define MBRP_OVER_BIT 21
`define MBRP_POS_BIT 20
`endif

/* File: pkg/mbrp_pkg.sv */
// Purpose: types for the meter readout port
// Assumes: nothing
// Notes: one-hot state codes
package mbrp_pkg;
  typedef enum logic [2:0] {
    MBRP_CONV = 3'h1,
    MBRP_SHOW = 3'h2,
    MBRP_HELD = 3'h4
  } mbrp_state_type;
endpackage

/* File: core/mbrp_skid.sv */
// Purpose: two-entry buffer between the converter and the result latch
// Assumes: one clock, synchronous reset
// Notes: holds a word while the taker stalls
`timescale 1ns/1ps
module mbrp_skid #(
  parameter int W = 24
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic [W-1:0] in_data_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  output logic [W-1:0] out_data_out,
  output logic out_valid_out,
  input wire logic out_ready_in
);
  logic [W-1:0] mem_reg [2];
  logic [1:0] count_reg;
  logic rd_reg;
  logic wr_reg;
  logic push;
  logic pop;

  assign push = in_valid_in && (count_reg != 2'h2);
  assign pop = out_ready_in && (count_reg != 2'h0);
  assign in_ready_out = (count_reg != 2'h2);
  assign out_valid_out = (count_reg != 2'h0);
  assign out_data_out = mem_reg[rd_reg];

  // pointers and fill level; full count is honest, no silent overwrite
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      count_reg <= 2'h0;
      rd_reg <= 1'b0;
      wr_reg <= 1'b0;
    end else begin
      if (push) wr_reg <= ~wr_reg;
      if (pop) rd_reg <= ~rd_reg;
      count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
    end
  end

  // storage
  always_ff @(posedge mclk_in) begin
    if (push) mem_reg[wr_reg] <= in_data_in;
  end
endmodule

/* File: core/mbrp_top.sv */
// Purpose: result output port of a 4 3/4 digit panel meter
// Assumes: conversion result arrives on result_* with valid/ready
// Notes: multiplexed BCD plus latched parallel option outputs
// Notes: status, data ready and every latched output move on the take edge
// Notes: hold is looked at only as a window ends or while held
`timescale 1ns/1ps
`include "mbrp_consts.svh"
module mbrp_top
  import mbrp_pkg::*;
#(
  parameter int PERIOD_CYC = `MBRP_PERIOD_CYC,
  parameter int VALID_CYC = `MBRP_VALID_CYC,
  parameter int STEP_CYC = `MBRP_STEP_CYC
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic hold_n_in,
  input wire logic [19:0] result_bcd_in,
  input wire logic result_over_in,
  input wire logic result_pos_in,
  input wire logic result_valid_in,
  output logic result_ready_out,
  output logic [3:0] bcd_out,
  output logic [4:0] digit_strobe_out,
  output logic status_out,
  output logic overload_out,
  output logic polarity_out,
  output logic mux_step_out,
  output logic [19:0] par_bcd_out,
  output logic par_polarity_out,
  output logic data_ready_out
);
  // counters span a whole conversion period at the full clock rate
  localparam int CW = 32;
  // result word: overload flag, polarity, then five BCD digits
  localparam int RW = `MBRP_WORD_W;

  mbrp_state_type state_reg;
  logic [CW-1:0] cyc_reg;
  logic [CW-1:0] step_cnt_reg;
  logic [2:0] digit_reg;
  logic [RW-1:0] word_reg;
  logic [RW-1:0] buf_data;
  logic buf_valid;
  logic take;
  logic conv_end;
  logic step_tick;
  // window end look-ahead and the digit under the scan pointer
  logic leave_show;
  logic [`MBRP_BCD_W-1:0] cur_digit;

  ////////////////////////////////////////////////////////////////////////
  // buffer: a word arriving while the port is showing waits here
  // two slots, so a word finished during a hold is not lost
  mbrp_skid #(.W(RW)) u_skid (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .in_data_in({result_over_in, result_pos_in, result_bcd_in}),
    .in_valid_in(result_valid_in),
    .in_ready_out(result_ready_out),
    .out_data_out(buf_data),
    .out_valid_out(buf_valid),
    .out_ready_in(take)
  );

  // conversion ends once per third of a second; then one word is taken
  // a late word stretches the gap; the next period starts from the take
  assign conv_end = (state_reg == MBRP_CONV) &&
    (cyc_reg >= CW'(PERIOD_CYC - VALID_CYC - 1));
  assign take = conv_end && buf_valid;
  assign step_tick = (state_reg != MBRP_CONV) &&
    (step_cnt_reg == CW'(STEP_CYC - 1));

  // the edge on which the sequencer goes back to converting; the status
  // and strobes look ahead at it so that they turn with the sequencer
  // instead of one cycle late, which would stretch the window
  assign leave_show = hold_n_in && (((state_reg == MBRP_SHOW) &&
    (cyc_reg == CW'(VALID_CYC - 1))) || (state_reg == MBRP_HELD));

  // digit picked by the scan pointer, units in the lowest nibble
  assign cur_digit = word_reg[digit_reg*`MBRP_BCD_W +: `MBRP_BCD_W];

  ////////////////////////////////////////////////////////////////////////
  // cycle sequencer: convert, show for the valid window, or sit held
  // the gap is the period less the window, so the rate holds whatever
  // the window length; a hold only stretches the time spent showing
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      state_reg <= MBRP_CONV;
      cyc_reg <= '0;
    end else begin
      case (state_reg)
        MBRP_CONV: begin
          // without a fresh word the conversion simply stretches
          if (take) begin
            state_reg <= MBRP_SHOW;
            cyc_reg <= '0;
          end else if (!conv_end) begin
            cyc_reg <= cyc_reg + CW'(1);
          end
        end
        MBRP_SHOW: begin
          if (cyc_reg == CW'(VALID_CYC - 1)) begin
            cyc_reg <= '0;
            state_reg <= hold_n_in ? MBRP_CONV : MBRP_HELD;
          end else begin
            cyc_reg <= cyc_reg + CW'(1);
          end
        end
        MBRP_HELD: begin
          // last result stays displayed; no new conversion starts
          if (hold_n_in) begin
            state_reg <= MBRP_CONV;
            cyc_reg <= '0;
          end
        end
        default: begin
          state_reg <= MBRP_CONV;
          cyc_reg <= '0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // latched result word, replaced only at conversion end
  // it feeds the digit scan; the parallel outputs load beside it
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      word_reg <= '0;
    end else if (take) begin
      word_reg <= buf_data;
    end
  end

  // status and parallel ready follow the sequencer's next state
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      status_out <= 1'b1;
      data_ready_out <= 1'b0;
    end else if (state_reg == MBRP_CONV) begin
      // a taken word opens the window on the edge that loads the data
      status_out <= !take;
      data_ready_out <= take;
    end else begin
      // both turn on the edge on which the sequencer leaves the window
      status_out <= leave_show;
      data_ready_out <= !leave_show;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // digit scan divider; the step pulse advances the digit pointer
  // the scan restarts at the units digit in every window
  always_ff @(posedge mclk_in) begin
    if (rst_in || (state_reg == MBRP_CONV)) begin
      step_cnt_reg <= '0;
      digit_reg <= 3'h0;
    end else if (step_tick) begin
      step_cnt_reg <= '0;
      if (digit_reg == 3'(`MBRP_DIGITS - 1)) digit_reg <= 3'h0;
      else digit_reg <= digit_reg + 3'h1;
    end else begin
      step_cnt_reg <= step_cnt_reg + CW'(1);
    end
  end

  // one-cycle step pulse for a remote parallel card
  // it leads the next strobe by one cycle, giving a remote card warning
  always_ff @(posedge mclk_in) begin
    if (rst_in) mux_step_out <= 1'b0;
    else mux_step_out <= step_tick;
  end

  ////////////////////////////////////////////////////////////////////////
  // multiplexed outputs: one strobe, its digit on the shared lines
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      digit_strobe_out <= 5'h00;
      bcd_out <= 4'h0;
    end else if ((state_reg == MBRP_CONV) || leave_show) begin
      // dark while converting, so no strobe stands beside a high status
      digit_strobe_out <= 5'h00;
      bcd_out <= 4'h0;
    end else begin
      digit_strobe_out <= 5'h01 << digit_reg;
      bcd_out <= cur_digit;
    end
  end

  // latched flags; loaded straight from the buffer as a word is taken,
  // so they already stand when status falls and hold through the next
  // conversion; loading from the result word would lag status by a cycle
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      overload_out <= 1'b0;
      polarity_out <= 1'b1;
      par_polarity_out <= 1'b1;
    end else if (take) begin
      overload_out <= buf_data[`MBRP_OVER_BIT];
      polarity_out <= buf_data[`MBRP_POS_BIT];
      par_polarity_out <= buf_data[`MBRP_POS_BIT];
    end
  end

  // parallel option word, loaded together with the flags
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      par_bcd_out <= '0;
    end else if (take) begin
      par_bcd_out <= buf_data[`MBRP_POS_BIT-1:0];
    end
  end
endmodule

/* File: test/mbrp_top_assertions.sv */
// Purpose: timing checks on the readout port
// Assumes: one clock, sync reset
// Notes: bound into mbrp_top
`timescale 1ns/1ps
module mbrp_top_chk #(
  parameter int VALID_CYC = 1500000
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic hold_n_in,
  input wire logic [3:0] bcd_out,
  input wire logic [4:0] digit_strobe_out,
  input wire logic status_out,
  input wire logic overload_out,
  input wire logic polarity_out,
  input wire logic mux_step_out,
  input wire logic [19:0] par_bcd_out,
  input wire logic par_polarity_out,
  input wire logic data_ready_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  int low_cnt;
  ////////////////////////////////////////
  // low stretch length; hold may only lengthen it
  always_ff @(posedge mclk_in) begin
    low_cnt <= status_out ? 0 : low_cnt + 1;
  end
  one_hot_a: assert property (
    $onehot0(digit_strobe_out) && (status_out -> digit_strobe_out == 5'h00))
    else $error("strobes not one-hot");
  first_digit_a: assert property (
    $fell(status_out) |=> digit_strobe_out == 5'h01) else $error("no units");
  digit_data_a: assert property (
    digit_strobe_out != 5'h00 |->
    bcd_out == 4'(par_bcd_out >> (4 * $clog2(digit_strobe_out))))
    else $error("digit data wrong");
  window_len_a: assert property (
    $rose(status_out) |-> low_cnt >= VALID_CYC) else $error("window short");
  ready_inv_a: assert property (
    data_ready_out == !status_out && par_polarity_out == polarity_out)
    else $error("data ready wrong");
  latch_keep_a: assert property (
    !$fell(status_out) |-> $stable({par_bcd_out, overload_out, polarity_out}))
    else $error("latch moved");
  step_pulse_a: assert property (
    mux_step_out |=> !mux_step_out) else $error("step pulse long");
  hold_keep_a: assert property (
    !hold_n_in && !status_out |=> !status_out) else $error("hold ignored");
  strobe_dwell_a: assert property (
    $rose(digit_strobe_out[1]) |-> digit_strobe_out[1] [*8])
    else $error("strobe short");
endmodule
bind mbrp_top mbrp_top_chk #(.VALID_CYC(VALID_CYC)) u_chk (.mclk_in, .rst_in,
  .hold_n_in, .bcd_out, .digit_strobe_out, .status_out, .overload_out,
  .polarity_out, .mux_step_out, .par_bcd_out, .par_polarity_out,
  .data_ready_out);

/* File: test/mbrp_capture.sv */
// Purpose: far-side capture logic model
// Assumes: samples on the rising clock
// Notes: keeps the last digits seen
`timescale 1ns/1ps
module mbrp_capture (
  input wire logic mclk_in,
  input wire logic [3:0] bcd_in,
  input wire logic [4:0] strobe_in,
  input wire logic status_in,
  input wire logic polarity_in,
  output logic [19:0] word_out,
  output logic leftmost_point_input_out
);
  // take a nibble per strobe, only while status is low
  always_ff @(posedge mclk_in) begin
    for (int i = 0; i < 5; i++) begin
      if (!status_in && strobe_in[i]) word_out[4*i +: 4] <= bcd_in;
    end
  end
  // polarity wired to the active-low leftmost point
  assign leftmost_point_input_out = polarity_in;
endmodule

/* File: test/tb_top.sv */
// Purpose: self-checking bench for mbrp_top
// Assumes: shortened counts, 100 ns clock
// Notes: inputs move 1 ns after the rising edge
`timescale 1ns/1ps
module tb_top;
  localparam int PER = 400;
  localparam int VAL = 100;
  localparam int STP = 10;
  logic mclk_in = 1'h0, rst_in = 1'h1, hold_n_in = 1'h1;
  logic [19:0] result_bcd_in = 20'h00000;
  logic result_over_in = 1'h0, result_pos_in = 1'h1, result_valid_in = 1'h0;
  logic result_ready_out, status_out, overload_out, polarity_out;
  logic mux_step_out, par_polarity_out, data_ready_out, point_n;
  logic [3:0] bcd_out;
  logic [4:0] digit_strobe_out;
  logic [19:0] par_bcd_out, cap_bcd;
  int n_errors = 0, n_compared = 0;
  int n_steps = 0;
  ////////////////////////////////////////
  mbrp_top #(.PERIOD_CYC(PER), .VALID_CYC(VAL), .STEP_CYC(STP)) u_mbrp_top (
    .mclk_in, .rst_in, .hold_n_in, .result_bcd_in, .result_over_in,
    .result_pos_in, .result_valid_in, .result_ready_out, .bcd_out,
    .digit_strobe_out, .status_out, .overload_out, .polarity_out,
    .mux_step_out, .par_bcd_out, .par_polarity_out, .data_ready_out);
  mbrp_capture u_mbrp_capture (.mclk_in, .bcd_in(bcd_out),
    .strobe_in(digit_strobe_out), .status_in(status_out),
    .polarity_in(polarity_out), .word_out(cap_bcd),
    .leftmost_point_input_out(point_n));
  // step pulses seen at rising edges, for the scan check
  always @(posedge mclk_in) begin
    if (mux_step_out === 1'h1) n_steps++;
  end
  // clock, and a watchdog well past the expected run
  initial begin
    forever #50 mclk_in = ~mclk_in;
  end
  initial begin
    repeat (20000) @(posedge mclk_in);
    n_errors++;
    wrap_up();
  end
  task automatic check(input string what, input logic [23:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  // request held until an edge where ready is high
  task automatic offer(input logic [19:0] w, input logic ov, pos);
    {result_bcd_in, result_over_in, result_pos_in} = {w, ov, pos};
    result_valid_in = 1'h1;
    while (result_ready_out !== 1'h1) tick(1);
    tick(1);
    result_valid_in = 1'h0;
  endtask
  task automatic wait_show(output int k);
    k = 0;
    while (status_out !== 1'h0 && k < 2 * PER) begin
      tick(1);
      k++;
    end
    check("wait", status_out, 1'h0);
  endtask
  task automatic t_show(input logic [19:0] w, input logic ov, pos);
    int k;
    int s0;
    offer(w, ov, pos);
    wait_show(k);
    s0 = n_steps;
    check("par", par_bcd_out, w);
    check("flags", {overload_out, par_polarity_out}, {ov, pos});
    tick(VAL - 1);
    check("window", {status_out, data_ready_out}, 2'h1);
    check("digits", cap_bcd, w);
    check("point", point_n, pos);
    tick(1);
    check("busy", status_out, 1'h1);
    check("steps", n_steps - s0 + mux_step_out, VAL / STP);
    $display("done show %h", w);
  endtask
  task automatic t_hold();
    int k;
    offer(20'h00123, 1'h0, 1'h1);
    wait_show(k);
    offer(20'h12345, 1'h0, 1'h1);
    tick(VAL);
    wait_show(k);
    check("rate", 1 + VAL + k, PER);
    hold_n_in = 1'h0;
    offer(20'h00007, 1'h0, 1'h1);
    // an edge passes so valid is never dropped and raised at once
    tick(1);
    offer(20'h00008, 1'h0, 1'h1);
    tick(VAL);
    check("held", {status_out, par_bcd_out}, {1'h0, 20'h12345});
    check("full", result_ready_out, 1'h0);
    hold_n_in = 1'h1;
    tick(2);
    check("resume", status_out, 1'h1);
    wait_show(k);
    check("next", {result_ready_out, par_bcd_out}, {1'h1, 20'h00007});
    tick(VAL);
    wait_show(k);
    check("last", par_bcd_out, 20'h00008);
    $display("done hold");
  endtask
  task automatic wrap_up();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // main sequence
  initial begin
    tick(4);
    rst_in = 1'h0;
    check("reset", {status_out, digit_strobe_out, polarity_out, bcd_out},
      {1'h1, 5'h00, 1'h1, 4'h0});
    t_show(20'h39999, 1'h0, 1'h1);
    t_show(20'h40000, 1'h1, 1'h0);
    t_hold();
    wrap_up();
  end
endmodule
